/* File: digital_mixer_sidetone_router_tb.sv */
// Self-checking bench for the sidetone and DAC mixing block
`default_nettype none
module digital_mixer_sidetone_router_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        aclk = 1'b0, aresetn = 1'b0, fire = 1'b0, strobe, ov;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [15:0] awaddr = 16'h0000, araddr = 16'h0000;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0]  bresp, rresp;
    logic [23:0] a = 24'h0, b = 24'h0, p1, p2, d1l, t1l;
    wire logic [10:0] cfg;
    logic [3:0]  mute = 4'h0;
    logic [33:0] q_r[$];
    logic [47:0] q_s[$];
    int          bad_count = 0, checked = 0;
    always #10 aclk = ~aclk;
    sample_feed feed (.aclk(aclk), .fire(fire), .a(a), .b(b),
        .strobe(strobe), .p1(p1), .p2(p2));
    mix_router #(.FAST_RAMP_CYCLES(512), .SLOW_RAMP_CYCLES(1024)) dut (
        .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
        .wready(wready), .wdata(wdata), .wstrb(4'hF), .bvalid(bvalid),
        .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .rvalid(rvalid),
        .rready(rready), .rdata(rdata), .rresp(rresp),
        .sample_strobe(strobe), .in1_left(p1), .in1_right(~p1),
        .in2_left(~p2), .in2_right(p2), .rx1_left(p1), .rx1_right(~p2),
        .rx2_left(p2), .rx2_right(~p1), .dac_mute(mute), .out_valid(ov),
        .dac1_left(d1l), .dac1_right(), .dac2_left(), .dac2_right(),
        .tx1_left(t1l), .tx1_right(), .tx2_left(), .tx2_right(),
        .unmute_ramp_enable(cfg[10]), .mute_ramp_speed(cfg[9]),
        .speaker_pdm_rate_sel(cfg[8]), .mic_pdm_rate_sel(cfg[7]),
        .record_rate_sel(cfg[6]), .playback_rate_sel(cfg[5]),
        .sidetone_lowpass_en(cfg[4]), .sidetone_highpass_en(cfg[3]),
        .sidetone_highpass_corner(cfg[2:0]));
    task automatic stop_test();
        if (bad_count == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [47:0] s, input logic [47:0] e);
        checked++;
        if (s !== e) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // Bus handshakes are judged at the falling edge, clear of the flops
    task automatic bus(input logic [15:0] idx, input logic [31:0] d,
                       input logic rd, input logic [33:0] e);
        int n;
        logic [2:0] hs;
        @(posedge aclk);
        if (rd) q_r.push_back(e);
        {araddr, awaddr} <= {2{idx[13:0], 2'b00}};
        wdata <= d;
        {arvalid, rready, awvalid, wvalid, bready} <= {rd, rd, !rd, !rd, !rd};
        for (n = 0; n < 40; n++) begin
            @(negedge aclk);
            hs = {awvalid & awready | arvalid & arready, wvalid & wready,
                  bvalid & bready | rvalid & rready};
            if (hs[0] && !rd) chk(bresp, e);
            @(posedge aclk);
            if (hs[2]) {arvalid, awvalid} <= 2'b00;
            if (hs[1]) wvalid <= 1'b0;
            if (hs[0]) break;
        end
        {bready, rready} <= 2'b00;
        if (n == 40) begin
            bad_count++;
            stop_test();
        end
    endtask
    task automatic frame(input logic [23:0] x, y, input logic [47:0] e);
        q_s.push_back(e);
        {a, b, fire} <= {x, y, 1'b1};
        @(posedge aclk);
        fire <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask
    // Scoreboard: results are matched against the oldest note
    always @(negedge aclk) begin
        if (rvalid === 1'b1 && rready === 1'b1)
            chk({rresp, rdata}, q_r.pop_front());
        if (ov === 1'b1)
            chk({d1l, t1l}, q_s.pop_front());
    end
    initial begin
        logic [23:0] x, y;
        int n;
        n = $urandom(18989);
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        bus(16'h0620, 0, 1, 34'h000D);
        bus(16'h0621, 0, 1, 34'h1000);
        bus(16'h0602, 0, 1, 34'h0000);
        bus(16'h0700, 0, 1, {2'h2, 32'h0});
        bus(16'h0601, 32'hFFFF, 0, 0);
        bus(16'h0601, 0, 1, 34'h0033);
        bus(16'h0620, 0, 0, 0);
        bus(16'h0621, 32'h0340, 0, 0);
        bus(16'h0610, 3, 0, 0);
        repeat (2) @(posedge aclk);
        chk(cfg, 11'h60E);
        bus(16'h0610, 0, 0, 0);
        bus(16'h0601, 3, 0, 0);
        bus(16'h0606, 2, 0, 0);
        for (n = 0; n < 4; n++) begin
            x = 24'($urandom) & 24'h3FFFFF;
            y = 24'($urandom) & 24'h3FFFFF;
            frame(x, y, {x + y, x});
        end
        frame(24'h700000, 24'h700000, {24'h7FFFFF, 24'h700000});
        bus(16'h0601, 0, 0, 0);
        frame(x, y, {24'h0, x});
        // Mute ramps down at the fast rate; status shows the ramp busy
        mute <= 4'h1;
        bus(16'h0611, 0, 1, 34'h1);
        repeat (600) @(posedge aclk);
        bus(16'h0611, 0, 1, 34'h0);
        bus(16'h0601, 3, 0, 0);
        frame(x, y, {24'h0, x});
        // Unmute without ramp jumps straight back to full level
        mute <= 4'h0;
        bus(16'h0611, 0, 1, 34'h0);
        // Plain right sidetone into pair two, input 2L into transmit
        bus(16'h0621, 0, 0, 0);
        bus(16'h0603, 32'h0300, 0, 0);
        bus(16'h0605, 32'h0020, 0, 0);
        bus(16'h0608, 2, 0, 0);
        frame(x, y, {x + y, x});
        chk(q_s.size() + q_r.size(), 0);
        stop_test();
    end
endmodule
`default_nettype wire

/* File: mix_pkg.sv */
// Constants shared by the sidetone and DAC mixing block
`default_nettype none
package mix_pkg;
    localparam int N_REGS = 14;
    // Slots of the register file
    localparam int S_DAC1_GAIN = 0;
    localparam int S_DAC1_L    = 1;
    localparam int S_DAC1_R    = 2;
    localparam int S_DAC2_GAIN = 3;
    localparam int S_DAC2_L    = 4;
    localparam int S_DAC2_R    = 5;
    localparam int S_TX1_L     = 6;
    localparam int S_TX_SEL    = 10;
    localparam int S_MUTE      = 11;
    localparam int S_OSR       = 12;
    localparam int S_SIDETONE  = 13;
    // Register indices, slot 13 first; byte address is four times these
    localparam logic [N_REGS-1:0][15:0] REG_IDX = {
        16'h0621, 16'h0620, 16'h0610, 16'h060A, 16'h0609, 16'h0608,
        16'h0607, 16'h0606, 16'h0605, 16'h0604, 16'h0603, 16'h0602,
        16'h0601, 16'h0600};
    localparam logic [15:0] IDX_STATUS = 16'h0611;
    // Implemented bits per slot
    localparam logic [N_REGS-1:0][15:0] REG_MASK = {
        16'h13C3, 16'h000F, 16'h0003, 16'h0001, 16'h0003, 16'h0003,
        16'h0003, 16'h0003, 16'h0033, 16'h0033, 16'h03FF, 16'h0033,
        16'h0033, 16'h03FF};
    // Reset values per slot
    localparam logic [N_REGS-1:0][15:0] REG_RESET = {
        16'h1000, 16'h000D, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h0000};
    // Field positions
    localparam int GAIN_R_LSB     = 5;
    localparam int GAIN_L_LSB     = 0;
    localparam int GAIN_W         = 5;
    localparam int SRC_ST_R_BIT   = 5;
    localparam int SRC_ST_L_BIT   = 4;
    localparam int SRC_RX2_BIT    = 1;
    localparam int SRC_RX1_BIT    = 0;
    localparam int TX_IN_BIT      = 1;
    localparam int TX_DAC_BIT     = 0;
    localparam int UNMUTE_BIT     = 1;
    localparam int RAMP_SPEED_BIT = 0;
    localparam int SPK_RATE_BIT   = 3;
    localparam int MIC_RATE_BIT   = 2;
    localparam int REC_RATE_BIT   = 1;
    localparam int PLAY_RATE_BIT  = 0;
    localparam int SIDETONE_LOWPASS_EN_BIT     = 12;
    localparam int HPF_CODE_LSB   = 7;
    localparam int SIDETONE_HIGHPASS_EN_BIT     = 6;
    localparam int ST_R_SRC_BIT   = 1;
    localparam int ST_L_SRC_BIT   = 0;
    // Timing and filter constants
    localparam int CLK_PERIOD_NS  = 20;
    localparam int FAST_RAMP_US   = 10700;
    localparam int SLOW_RAMP_US   = 171000;
    localparam int RAMP_STEPS     = 256;
    localparam logic [8:0] RAMP_FULL = 9'h100;
    localparam logic [3:0] LPF_SHIFT = 4'h2;
    localparam logic [3:0] HPF_SHIFT_BASE = 4'h2;
    localparam logic [2:0] HPF_RESERVED = 3'h7;
    localparam logic [2:0] HPF_LOWEST = 3'h6;
    localparam int GAIN_FRAC = 15;
    localparam logic [15:0] GAIN_UNITY = 16'h8000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Linear Q1.15 gain for a 1.5 dB step code; undefined codes give 0 dB
    function automatic logic [15:0] gain_of(input logic [4:0] code);
        case (code)
            5'h00: gain_of = 16'h0207;
            5'h01: gain_of = 16'h0269;
            5'h02: gain_of = 16'h02DE;
            5'h03: gain_of = 16'h0368;
            5'h04: gain_of = 16'h040C;
            5'h05: gain_of = 16'h04D0;
            5'h06: gain_of = 16'h05B8;
            5'h07: gain_of = 16'h06CC;
            5'h08: gain_of = 16'h0814;
            5'h09: gain_of = 16'h0999;
            5'h0A: gain_of = 16'h0B68;
            5'h0B: gain_of = 16'h0D8F;
            5'h0C: gain_of = 16'h101D;
            5'h0D: gain_of = 16'h1327;
            5'h0E: gain_of = 16'h16C3;
            5'h0F: gain_of = 16'h1B0D;
            5'h10: gain_of = 16'h2027;
            5'h11: gain_of = 16'h2637;
            5'h12: gain_of = 16'h2D6B;
            5'h13: gain_of = 16'h35FA;
            5'h14: gain_of = 16'h4027;
            5'h15: gain_of = 16'h4C3F;
            5'h16: gain_of = 16'h5A9E;
            5'h17: gain_of = 16'h6BB3;
            default: gain_of = GAIN_UNITY;
        endcase
    endfunction
endpackage
`default_nettype wire

/* File: mix_router.sv */
// Sidetone, DAC mixing and transmit routing with AXI4-Lite registers
`default_nettype none
module mix_router
    import mix_pkg::*;
#(
    parameter int DATA_W           = 24,
    parameter int ADDR_W           = 16,
    parameter int FAST_RAMP_CYCLES = FAST_RAMP_US * 1000 / CLK_PERIOD_NS,
    parameter int SLOW_RAMP_CYCLES = SLOW_RAMP_US * 1000 / CLK_PERIOD_NS
) (
    // Clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // AXI4-Lite write
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              wvalid,
    output logic                   wready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    output logic                   bvalid,
    input  wire logic              bready,
    output logic [1:0]             bresp,
    // AXI4-Lite read
    input  wire logic              arvalid,
    output logic                   arready,
    input  wire logic [ADDR_W-1:0] araddr,
    output logic                   rvalid,
    input  wire logic              rready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    // Samples in
    input  wire logic              sample_strobe,
    input  wire logic [DATA_W-1:0] in1_left,
    input  wire logic [DATA_W-1:0] in1_right,
    input  wire logic [DATA_W-1:0] in2_left,
    input  wire logic [DATA_W-1:0] in2_right,
    input  wire logic [DATA_W-1:0] rx1_left,
    input  wire logic [DATA_W-1:0] rx1_right,
    input  wire logic [DATA_W-1:0] rx2_left,
    input  wire logic [DATA_W-1:0] rx2_right,
    input  wire logic [3:0]        dac_mute,
    // Samples out
    output logic                   out_valid,
    output logic [DATA_W-1:0]      dac1_left,
    output logic [DATA_W-1:0]      dac1_right,
    output logic [DATA_W-1:0]      dac2_left,
    output logic [DATA_W-1:0]      dac2_right,
    output logic [DATA_W-1:0]      tx1_left,
    output logic [DATA_W-1:0]      tx1_right,
    output logic [DATA_W-1:0]      tx2_left,
    output logic [DATA_W-1:0]      tx2_right,
    // Settings for neighbouring blocks
    output logic                   unmute_ramp_enable,
    output logic                   mute_ramp_speed,
    output logic                   speaker_pdm_rate_sel,
    output logic                   mic_pdm_rate_sel,
    output logic                   record_rate_sel,
    output logic                   playback_rate_sel,
    output logic                   sidetone_lowpass_en,
    output logic                   sidetone_highpass_en,
    output logic [2:0]             sidetone_highpass_corner
);
    // Ramp tick spacing, rounded down so a full ramp never runs long
    localparam int FAST_DIV = FAST_RAMP_CYCLES / RAMP_STEPS;
    localparam int SLOW_DIV = SLOW_RAMP_CYCLES / RAMP_STEPS;
    localparam logic [23:0] FAST_TICK = 24'((FAST_DIV < 1) ? 1 : FAST_DIV);
    localparam logic [23:0] SLOW_TICK = 24'((SLOW_DIV < 1) ? 1 : SLOW_DIV);

    typedef struct packed {
        logic [N_REGS-1:0][15:0] regs;
        logic                    aw_got;
        logic [ADDR_W-1:0]       aw_addr;
        logic                    w_got;
        logic [15:0]             w_data;
        logic [1:0]              w_strb;
        logic                    awready;
        logic                    wready;
        logic                    bvalid;
        logic [1:0]              bresp;
        logic                    arready;
        logic                    rvalid;
        logic [31:0]             rdata;
        logic [1:0]              rresp;
        logic [3:0][8:0]         lvl;
        logic [23:0]             tick_cnt;
        logic [1:0][DATA_W-1:0]  hp_st;
        logic [1:0][DATA_W-1:0]  lp_st;
        logic [3:0][DATA_W-1:0]  dac;
        logic [3:0][DATA_W-1:0]  tx;
        logic                    out_valid;
    } state_t;

    state_t q_reg;
    state_t q_next;

    // Sign extension by two guard bits
    function automatic logic [DATA_W+1:0] ext(input logic [DATA_W-1:0] x);
        ext = {{2{x[DATA_W-1]}}, x};
    endfunction

    // Clamp to full scale instead of wrapping
    function automatic logic [DATA_W-1:0] sat(input logic [DATA_W+1:0] v);
        if (v[DATA_W+1:DATA_W-1] == 3'h0 || v[DATA_W+1:DATA_W-1] == 3'h7)
            sat = v[DATA_W-1:0];
        else
            sat = {v[DATA_W+1], {(DATA_W-1){~v[DATA_W+1]}}};
    endfunction

    // Gain never exceeds unity, so the product always fits
    function automatic logic [DATA_W-1:0] amp(input logic [DATA_W-1:0] x,
                                              input logic [4:0] code);
        logic signed [DATA_W+16:0] p;
        p = $signed(x) * $signed({1'b0, gain_of(code)});
        amp = p[DATA_W+GAIN_FRAC-1:GAIN_FRAC];
    endfunction

    // Soft-mute level applied to a mixer output
    function automatic logic [DATA_W-1:0] fade(input logic [DATA_W-1:0] x,
                                               input logic [8:0] lv);
        logic signed [DATA_W+9:0] p;
        p = $signed(x) * $signed({1'b0, lv});
        fade = p[DATA_W+7:8];
    endfunction

    // One-pole smoothing step; state stays between old value and input
    function automatic logic [DATA_W-1:0] step(input logic [DATA_W-1:0] st,
                                               input logic [DATA_W-1:0] x,
                                               input logic [3:0] sh);
        logic signed [DATA_W+1:0] df;
        logic [DATA_W+1:0]        nx;
        df = $signed(ext(x) - ext(st));
        nx = ext(st) + (DATA_W+2)'(df >>> sh);
        step = nx[DATA_W-1:0];
    endfunction

    function automatic logic [15:0] word_idx(input logic [ADDR_W-1:0] a);
        word_idx = 16'(a >> 2);
    endfunction

    // Sidetone source and filter settings
    logic [15:0] st_cfg;
    logic [2:0]  hp_code;
    logic [3:0]  hp_sh;
    logic [1:0][DATA_W-1:0] st_raw;
    logic [1:0][DATA_W-1:0] hp_new;
    logic [1:0][DATA_W-1:0] hp_out;
    logic [1:0][DATA_W-1:0] lp_new;
    logic [1:0][DATA_W-1:0] st_out;
    assign st_cfg = q_reg.regs[S_SIDETONE];
    assign st_raw[0] = st_cfg[ST_L_SRC_BIT] ? in2_left : in1_left;
    assign st_raw[1] = st_cfg[ST_R_SRC_BIT] ? in2_right : in1_right;
    // Reserved code falls back to the lowest corner
    assign hp_code = (st_cfg[HPF_CODE_LSB +: 3] == HPF_RESERVED) ?
                     HPF_LOWEST : st_cfg[HPF_CODE_LSB +: 3];
    assign hp_sh = HPF_SHIFT_BASE + {1'b0, hp_code};

    // Per side: high-pass as input minus its smoothed copy, then low-pass
    for (genvar s = 0; s < 2; s++) begin : g_st
        assign hp_new[s] = step(q_reg.hp_st[s], st_raw[s], hp_sh);
        assign hp_out[s] = st_cfg[SIDETONE_HIGHPASS_EN_BIT] ?
            sat(ext(st_raw[s]) - ext(hp_new[s])) : st_raw[s];
        assign lp_new[s] = step(q_reg.lp_st[s], hp_out[s], LPF_SHIFT);
        assign st_out[s] = st_cfg[SIDETONE_LOWPASS_EN_BIT] ?
            lp_new[s] : hp_out[s];
    end

    // DAC mixers: channels 0..3 are 1L, 1R, 2L, 2R
    logic [3:0][DATA_W-1:0] mix;
    logic [3:0][DATA_W-1:0] mix_f;
    for (genvar c = 0; c < 4; c++) begin : g_dac
        localparam int RS = (c < 2) ? S_DAC1_L + c : S_DAC2_L + c - 2;
        localparam int GS = (c < 2) ? S_DAC1_GAIN : S_DAC2_GAIN;
        logic [15:0]       rt;
        logic [15:0]       gn;
        logic [DATA_W-1:0] r1;
        logic [DATA_W-1:0] r2;
        assign rt = q_reg.regs[RS];
        assign gn = q_reg.regs[GS];
        assign r1 = (c % 2 == 1) ? rx1_right : rx1_left;
        assign r2 = (c % 2 == 1) ? rx2_right : rx2_left;
        // Each source only while its enable is set
        assign mix[c] = sat(
            (rt[SRC_ST_R_BIT] ?
                ext(amp(st_out[1], gn[GAIN_R_LSB +: GAIN_W])) : '0) +
            (rt[SRC_ST_L_BIT] ?
                ext(amp(st_out[0], gn[GAIN_L_LSB +: GAIN_W])) : '0) +
            (rt[SRC_RX2_BIT] ? ext(r2) : '0) +
            (rt[SRC_RX1_BIT] ? ext(r1) : '0));
        assign mix_f[c] = fade(mix[c], q_reg.lvl[c]);
    end

    // Transmit mixers fed by the selected DAC pair
    logic                   pair_two;
    logic [3:0][DATA_W-1:0] in_all;
    logic [3:0][DATA_W-1:0] tx_mix;
    assign pair_two = q_reg.regs[S_TX_SEL][0];
    assign in_all = {in2_right, in2_left, in1_right, in1_left};
    for (genvar k = 0; k < 4; k++) begin : g_tx
        logic [15:0]       rt;
        logic [DATA_W-1:0] dsel;
        assign rt = q_reg.regs[S_TX1_L + k];
        assign dsel = pair_two ? q_reg.dac[2 + k % 2] :
                                 q_reg.dac[k % 2];
        assign tx_mix[k] = sat((rt[TX_IN_BIT] ? ext(in_all[k]) : '0) +
            (rt[TX_DAC_BIT] ? ext(dsel) : '0));
    end

    // Shared ramp tick; speed chosen by the rate bit
    logic        ramp_slow;
    logic        unmute_ramp;
    logic        tick;
    logic [23:0] tick_len;
    logic [3:0]  busy;
    assign ramp_slow = q_reg.regs[S_MUTE][RAMP_SPEED_BIT];
    assign unmute_ramp = q_reg.regs[S_MUTE][UNMUTE_BIT];
    assign tick_len = ramp_slow ? SLOW_TICK : FAST_TICK;
    assign tick = q_reg.tick_cnt >= tick_len - 24'h000001;
    for (genvar c = 0; c < 4; c++) begin : g_busy
        assign busy[c] = q_reg.lvl[c] != (dac_mute[c] ? 9'h000 : RAMP_FULL);
    end

    // Next-state logic for bus, ramps and sample path
    always_comb begin
        logic        hit;
        logic [15:0] wmask;
        logic [15:0] ridx;
        hit = 1'b0;
        wmask = '0;
        ridx = '0;
        q_next = q_reg;
        // Address and data may arrive in either order
        if (awvalid && q_reg.awready) begin
            q_next.aw_got = 1'b1;
            q_next.aw_addr = awaddr;
        end
        if (wvalid && q_reg.wready) begin
            q_next.w_got = 1'b1;
            q_next.w_data = wdata[15:0];
            q_next.w_strb = wstrb[1:0];
        end
        if (bready && q_reg.bvalid)
            q_next.bvalid = 1'b0;
        if (q_next.aw_got && q_next.w_got) begin
            wmask = {{8{q_next.w_strb[1]}}, {8{q_next.w_strb[0]}}};
            for (int i = 0; i < N_REGS; i++) begin
                if (word_idx(q_next.aw_addr) == REG_IDX[i]) begin
                    hit = 1'b1;
                    q_next.regs[i] = ((q_reg.regs[i] & ~wmask) |
                        (q_next.w_data & wmask)) & REG_MASK[i];
                end
            end
            q_next.bresp = hit ? RESP_OKAY : RESP_SLVERR;
            q_next.bvalid = 1'b1;
            q_next.aw_got = 1'b0;
            q_next.w_got = 1'b0;
        end
        q_next.awready = !q_next.aw_got && !q_next.bvalid;
        q_next.wready = !q_next.w_got && !q_next.bvalid;
        // Read: one outstanding, answered the cycle after acceptance
        if (rready && q_reg.rvalid)
            q_next.rvalid = 1'b0;
        if (arvalid && q_reg.arready) begin
            ridx = word_idx(araddr);
            q_next.rvalid = 1'b1;
            q_next.rdata = '0;
            q_next.rresp = RESP_SLVERR;
            if (ridx == IDX_STATUS) begin
                q_next.rdata = {28'h0000000, busy};
                q_next.rresp = RESP_OKAY;
            end
            for (int i = 0; i < N_REGS; i++) begin
                if (ridx == REG_IDX[i]) begin
                    q_next.rdata = {16'h0000, q_reg.regs[i]};
                    q_next.rresp = RESP_OKAY;
                end
            end
        end
        q_next.arready = !q_next.rvalid;
        // Mute ramps; unmute jumps unless the ramp is enabled
        q_next.tick_cnt = tick ? '0 : q_reg.tick_cnt + 24'h000001;
        for (int c = 0; c < 4; c++) begin
            if (!dac_mute[c] && !unmute_ramp)
                q_next.lvl[c] = RAMP_FULL;
            else if (tick && dac_mute[c] && q_reg.lvl[c] != 9'h000)
                q_next.lvl[c] = q_reg.lvl[c] - 9'h001;
            else if (tick && !dac_mute[c] && q_reg.lvl[c] != RAMP_FULL)
                q_next.lvl[c] = q_reg.lvl[c] + 9'h001;
        end
        // Whole frame moves on the strobe
        q_next.out_valid = sample_strobe;
        if (sample_strobe) begin
            q_next.hp_st = hp_new;
            q_next.lp_st = lp_new;
            q_next.dac = mix_f;
            q_next.tx = tx_mix;
        end
    end

    // State register, synchronous reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q_reg <= '0;
            q_reg.regs <= REG_RESET;
        end else begin
            q_reg <= q_next;
        end
    end

    // Outputs straight from the state register
    assign awready = q_reg.awready;
    assign wready = q_reg.wready;
    assign bvalid = q_reg.bvalid;
    assign bresp = q_reg.bresp;
    assign arready = q_reg.arready;
    assign rvalid = q_reg.rvalid;
    assign rdata = q_reg.rdata;
    assign rresp = q_reg.rresp;
    assign out_valid = q_reg.out_valid;
    assign dac1_left = q_reg.dac[0];
    assign dac1_right = q_reg.dac[1];
    assign dac2_left = q_reg.dac[2];
    assign dac2_right = q_reg.dac[3];
    assign tx1_left = q_reg.tx[0];
    assign tx1_right = q_reg.tx[1];
    assign tx2_left = q_reg.tx[2];
    assign tx2_right = q_reg.tx[3];
    assign unmute_ramp_enable = unmute_ramp;
    assign mute_ramp_speed = ramp_slow;
    // Rate selects for the converters, then the sidetone filter settings
    assign speaker_pdm_rate_sel = q_reg.regs[S_OSR][SPK_RATE_BIT];
    assign mic_pdm_rate_sel = q_reg.regs[S_OSR][MIC_RATE_BIT];
    assign record_rate_sel = q_reg.regs[S_OSR][REC_RATE_BIT];
    assign playback_rate_sel = q_reg.regs[S_OSR][PLAY_RATE_BIT];
    assign sidetone_lowpass_en = st_cfg[SIDETONE_LOWPASS_EN_BIT];
    assign sidetone_highpass_en = st_cfg[SIDETONE_HIGHPASS_EN_BIT];
    assign sidetone_highpass_corner = st_cfg[HPF_CODE_LSB +: 3];

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence tx_dac_only_s;
        sample_strobe && q_reg.regs[S_TX1_L][1:0] == 2'h1 && !pair_two;
    endsequence

    sequence st_plain_s;
        sample_strobe && st_cfg == 16'h0000 && q_reg.lvl[3] == RAMP_FULL
        && q_reg.regs[S_DAC2_R][5:0] == 6'h20
        && q_reg.regs[S_DAC2_GAIN][9:5] == 5'h18;
    endsequence

    osr_reset_a: assert property (
        $rose(aresetn) |-> speaker_pdm_rate_sel && mic_pdm_rate_sel
            && !record_rate_sel && playback_rate_sel)
        else $error("rate selects wrong after reset");

    mix_silent_a: assert property (
        sample_strobe && q_reg.regs[S_DAC1_L] == 16'h0000
        |=> dac1_left == '0)
        else $error("mixer with no source not silent");

    tx_dac_path_a: assert property (
        tx_dac_only_s |=> tx1_left == $past(dac1_left))
        else $error("transmit did not take pair one left");

    tx_in_path_a: assert property (
        sample_strobe && q_reg.regs[S_TX1_L + 2][1:0] == 2'h2
        |=> tx2_left == $past(in2_left))
        else $error("transmit did not take input 2L");

    st_route_a: assert property (
        st_plain_s |=> dac2_right == $past(in1_right))
        else $error("plain sidetone path not unity");

    unmute_jump_a: assert property (
        !dac_mute[0] && !unmute_ramp |=> q_reg.lvl[0] == RAMP_FULL)
        else $error("unmute did not jump to full");

    unmute_ramp_a: assert property (
        !dac_mute[0] && unmute_ramp && q_reg.lvl[0] != RAMP_FULL && !tick
        |=> $stable(q_reg.lvl[0]))
        else $error("ramp moved between ticks");

    fast_tick_a: assert property (
        !ramp_slow && q_reg.tick_cnt >= FAST_TICK - 24'h000001
        |=> q_reg.tick_cnt == 24'h000000)
        else $error("fast ramp tick late");

    tick_bound_a: assert property (
        q_reg.tick_cnt < SLOW_TICK)
        else $error("ramp tick counter overran");

    bresp_hold_a: assert property (
        bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped");

    read_answer_a: assert property (
        arvalid && arready |=> rvalid)
        else $error("read not answered next cycle");
endmodule
`default_nettype wire

/* File: sample_feed.sv */
// Behavioural feed of sample frames from the neighbouring datapaths
`default_nettype none
module sample_feed (
    // Clock, trigger and frame data
    input  wire logic        aclk,
    input  wire logic        fire,
    input  wire logic [23:0] a,
    input  wire logic [23:0] b,
    // Frame towards the mixer
    output logic             strobe,
    output logic [23:0]      p1,
    output logic [23:0]      p2
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        strobe = 1'b0;
        p1 = 24'h000000;
        p2 = 24'h000000;
    end
    // Paths toggle between frames so stale data never looks valid
    always @(posedge aclk) begin
        strobe <= fire;
        p1 <= fire ? a : ~p1;
        p2 <= fire ? b : ~p2;
    end
endmodule
`default_nettype wire
